// file: logic/buck_regs_defs.svh
// Constants of the regulator settings bank: offsets, fields, resets, figures.
// Assumes an 8-bit register address and 8-bit data port.
`ifndef BUCK_REGS_DEFS_SVH
`define BUCK_REGS_DEFS_SVH

`define ADDR_CURRENT_LIMIT 8'hD0
`define ADDR_RAMP_MODE 8'hD1
`define ADDR_PHASE 8'hD2
`define ADDR_AUTO_THRESHOLD 8'hD4
`define ADDR_BASE_VOLTAGE 8'hD5
`define ADDR_CEILING 8'hD6
`define ADDR_TARGET_STATUS 8'hD7

`define FIELD_ALARM_MARGIN 4
`define FIELD_LIMIT 3:0
`define FIELD_RAMP_DOWN 7:5
`define FIELD_RAMP_UP 4:2
`define FIELD_MODE 1:0
`define FIELD_SHED 3
`define FIELD_PHASE 2:0
`define FIELD_VOLTAGE 6:0

`define RESET_LIMIT 4'h0
`define RESET_RAMP 3'h0
`define RESET_MODE 2'h0
`define RESET_PHASE 3'h3
`define RESET_VOLTAGE 7'h00
`define RESET_CEILING 7'h7F

`define LIMIT_BASE_MA 13'h0640
`define LIMIT_STEP_MA 13'h00C8
`define LIMIT_TOP_MA 13'h1068
`define MARGIN_SMALL_MA 13'h012C
`define MARGIN_LARGE_MA 13'h0258
`define SHED_LOW_MA 13'h0320
`define SHED_HIGH_MA 13'h04B0

`define MODE_BY_SET 2'h0
`define MODE_LOW_POWER 2'h1
`define MODE_NORMAL 2'h2
`define MODE_AUTO 2'h3
`define RATE_IMMEDIATE 3'h7
`define PHASE_EIGHT_BIT 2

`define CLK_PERIOD_NS 50
`define SLEW_MIN_UV_PER_US 1250
`define SUB_UNITS_PER_MV 16
`define UNITS_PER_CODE 15'h00A0
`define SLEW_BASE_STEP ((`SLEW_MIN_UV_PER_US * `SUB_UNITS_PER_MV * `CLK_PERIOD_NS) / 1000000)

`endif

// file: logic/buck_regs_pkg.sv
// Types of the regulator settings bank.
// Assumes the constants header is compiled alongside.
package buck_regs_pkg;

	typedef struct packed {
		logic alarm_margin_sel;
		logic [3:0] phase_current_limit;
		logic [2:0] ramp_down_rate;
		logic [2:0] ramp_up_rate;
		logic [1:0] op_mode;
		logic shed_enable;
		logic [2:0] phase_count;
		logic [6:0] auto_mode_threshold;
		logic [6:0] step_port_base_voltage;
		logic [6:0] voltage_ceiling;
	} regs_type;

	typedef enum logic [1:0] {RAMP_OFF, RAMP_MOVE, RAMP_HOLD, RAMP_FALL} ramp_state_type;

	typedef struct packed {
		logic [6:0] vout_code;
		logic done;
	} ramp_out_type;

	typedef struct packed {
		logic low_power;
		logic [3:0] phases;
		logic shedding;
	} mode_out_type;

endpackage

// file: logic/ramp_gen.sv
// Output voltage ramp: slews toward the target at the programmed rates.
// Assumes target and rates come from flops on the same clock.
`timescale 1ns/1ps
`include "buck_regs_defs.svh"
module ramp_gen import buck_regs_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [6:0] target,
	input wire logic [2:0] up_rate,
	input wire logic [2:0] down_rate,
	output ramp_out_type ramp_out
);

	typedef struct packed {
		ramp_state_type state;
		logic [14:0] level;
		ramp_out_type out;
	} ramp_reg_type;

	ramp_reg_type cur;
	ramp_reg_type next_cur;

	function automatic logic [14:0] slew_step(input logic [2:0] rate);
		logic [14:0] base;
		base = 15'(`SLEW_BASE_STEP);
		case (rate)
			3'h0: slew_step = base;
			3'h1: slew_step = 15'(base * 2);
			3'h2: slew_step = 15'(base * 4);
			3'h3: slew_step = 15'(base * 8);
			3'h4: slew_step = 15'(base * 16);
			3'h5: slew_step = 15'(base * 24);
			default: slew_step = 15'(base * 32);
		endcase
	endfunction

	logic [14:0] goal;

	always_comb begin
		next_cur = cur;
		goal = 15'(target * `UNITS_PER_CODE);
		case (cur.state)
			RAMP_OFF: begin
				if (enable) begin
					next_cur.state = RAMP_MOVE;
				end
			end
			RAMP_MOVE, RAMP_HOLD: begin
				if (!enable) begin
					next_cur.state = RAMP_FALL;
				end else if (up_rate == `RATE_IMMEDIATE) begin
					next_cur.level = goal;
					next_cur.state = RAMP_HOLD;
				end else if (cur.level + slew_step(up_rate) <= goal) begin
					next_cur.level = cur.level + slew_step(up_rate);
					next_cur.state = RAMP_MOVE;
				end else if (cur.level > goal + slew_step(down_rate)) begin
					next_cur.level = cur.level - slew_step(down_rate);
					next_cur.state = RAMP_MOVE;
				end else begin
					next_cur.level = goal;
					next_cur.state = RAMP_HOLD;
				end
			end
			default: begin
				if (enable) begin
					next_cur.state = RAMP_MOVE;
				end else if (cur.level > slew_step(down_rate)) begin
					next_cur.level = cur.level - slew_step(down_rate);
				end else begin
					next_cur.level = 15'h0000;
					next_cur.state = RAMP_OFF;
				end
			end
		endcase
		next_cur.out.vout_code = 7'(next_cur.level / `UNITS_PER_CODE);
		next_cur.out.done = (next_cur.state == RAMP_HOLD);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign ramp_out = cur.out;

endmodule

// file: logic/mode_sel.sv
// Operating mode, phase count and phase shedding decision.
// Assumes inputs come from flops on the same clock.
`timescale 1ns/1ps
`include "buck_regs_defs.svh"
module mode_sel import buck_regs_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire regs_type regs,
	input wire logic set_low_power,
	input wire logic [6:0] target,
	input wire logic dual_mode,
	input wire logic [12:0] phase_current,
	output mode_out_type mode_out
);

	mode_out_type cur;
	mode_out_type next_cur;
	logic [3:0] chosen;

	always_comb begin
		next_cur = cur;
		case (regs.op_mode)
			`MODE_BY_SET: next_cur.low_power = set_low_power;
			`MODE_LOW_POWER: next_cur.low_power = 1'b1;
			`MODE_NORMAL: next_cur.low_power = 1'b0;
			default: next_cur.low_power = (target < regs.auto_mode_threshold);
		endcase
		if (regs.phase_count[`PHASE_EIGHT_BIT]) begin
			chosen = dual_mode ? 4'h8 : 4'h4;
		end else begin
			chosen = 4'(regs.phase_count[1:0]) + 4'h1;
		end
		if (!regs.shed_enable || next_cur.low_power) begin
			next_cur.shedding = 1'b0;
		end else if (phase_current < `SHED_LOW_MA) begin
			next_cur.shedding = 1'b1;
		end else if (phase_current > `SHED_HIGH_MA) begin
			next_cur.shedding = 1'b0;
		end
		next_cur.phases = next_cur.shedding ? 4'h1 : chosen;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign mode_out = cur;

endmodule

// file: logic/buck_regulator_settings_regs.sv
// Regulator settings register bank with voltage-step port, ramp and mode control.
// Assumes a same-clock register port; step pins are asynchronous.
`timescale 1ns/1ps
`include "buck_regs_defs.svh"
module buck_regulator_settings_regs import buck_regs_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic BUCK_ENABLE,
	input wire logic STEP_PORT_ENABLE,
	input wire logic SET_B_SELECTED,
	input wire logic SET_A_LOW_POWER,
	input wire logic SET_B_LOW_POWER,
	input wire logic [6:0] SET_VOLTAGE,
	input wire logic STEP_UP,
	input wire logic STEP_DOWN,
	input wire logic DUAL_MODE,
	input wire logic [12:0] PHASE_CURRENT,
	output logic [6:0] VOUT_CODE,
	output logic RAMP_DONE,
	output logic LOW_POWER,
	output logic [3:0] PHASES_ACTIVE,
	output logic PHASE_SHEDDING,
	output logic [12:0] CURRENT_LIMIT_MA,
	output logic [12:0] ALARM_LEVEL_MA,
	output logic OVER_CURRENT_ALARM,
	output logic [6:0] ACTIVE_TARGET
);

	typedef struct packed {
		regs_type regs;
		logic [7:0] rdata;
		logic rvalid;
		logic [2:0] up_sync;
		logic [2:0] down_sync;
		logic step_on;
		logic [6:0] step_target;
		logic [6:0] target;
		logic set_low_power;
		logic [12:0] limit_ma;
		logic [12:0] alarm_ma;
		logic alarm;
	} top_reg_type;

	top_reg_type cur;
	top_reg_type next_cur;
	ramp_out_type ramp_out;
	mode_out_type mode_out;

	logic up_edge;
	logic down_edge;
	logic [6:0] wanted;
	logic [12:0] raw_limit;
	logic [12:0] margin;

	always_comb begin
		next_cur = cur;
		next_cur.rvalid = 1'b0;

		// Register writes
		if (REG_WR) begin
			if (REG_ADDR == `ADDR_CURRENT_LIMIT) begin
				next_cur.regs.alarm_margin_sel = REG_WDATA[`FIELD_ALARM_MARGIN];
				next_cur.regs.phase_current_limit = REG_WDATA[`FIELD_LIMIT];
			end else if (REG_ADDR == `ADDR_RAMP_MODE) begin
				next_cur.regs.ramp_down_rate = REG_WDATA[`FIELD_RAMP_DOWN];
				next_cur.regs.ramp_up_rate = REG_WDATA[`FIELD_RAMP_UP];
				next_cur.regs.op_mode = REG_WDATA[`FIELD_MODE];
			end else if (REG_ADDR == `ADDR_PHASE) begin
				next_cur.regs.shed_enable = REG_WDATA[`FIELD_SHED];
				next_cur.regs.phase_count = REG_WDATA[`FIELD_PHASE];
			end else if (REG_ADDR == `ADDR_AUTO_THRESHOLD) begin
				next_cur.regs.auto_mode_threshold = REG_WDATA[`FIELD_VOLTAGE];
			end else if (REG_ADDR == `ADDR_BASE_VOLTAGE) begin
				next_cur.regs.step_port_base_voltage = REG_WDATA[`FIELD_VOLTAGE];
			end else if (REG_ADDR == `ADDR_CEILING) begin
				next_cur.regs.voltage_ceiling = REG_WDATA[`FIELD_VOLTAGE];
			end
		end

		// Register reads, reserved bits and unmapped addresses read zero
		if (REG_RD) begin
			next_cur.rvalid = 1'b1;
			next_cur.rdata = 8'h00;
			if (REG_ADDR == `ADDR_CURRENT_LIMIT) begin
				next_cur.rdata[`FIELD_ALARM_MARGIN] = cur.regs.alarm_margin_sel;
				next_cur.rdata[`FIELD_LIMIT] = cur.regs.phase_current_limit;
			end else if (REG_ADDR == `ADDR_RAMP_MODE) begin
				next_cur.rdata[`FIELD_RAMP_DOWN] = cur.regs.ramp_down_rate;
				next_cur.rdata[`FIELD_RAMP_UP] = cur.regs.ramp_up_rate;
				next_cur.rdata[`FIELD_MODE] = cur.regs.op_mode;
			end else if (REG_ADDR == `ADDR_PHASE) begin
				next_cur.rdata[`FIELD_SHED] = cur.regs.shed_enable;
				next_cur.rdata[`FIELD_PHASE] = cur.regs.phase_count;
			end else if (REG_ADDR == `ADDR_AUTO_THRESHOLD) begin
				next_cur.rdata[`FIELD_VOLTAGE] = cur.regs.auto_mode_threshold;
			end else if (REG_ADDR == `ADDR_BASE_VOLTAGE) begin
				next_cur.rdata[`FIELD_VOLTAGE] = cur.regs.step_port_base_voltage;
			end else if (REG_ADDR == `ADDR_CEILING) begin
				next_cur.rdata[`FIELD_VOLTAGE] = cur.regs.voltage_ceiling;
			end else if (REG_ADDR == `ADDR_TARGET_STATUS) begin
				next_cur.rdata[`FIELD_VOLTAGE] = cur.step_target;
			end
		end

		// Step pin synchronisers; edges use the second and third stages
		next_cur.up_sync = {cur.up_sync[1:0], STEP_UP};
		next_cur.down_sync = {cur.down_sync[1:0], STEP_DOWN};
		up_edge = cur.up_sync[1] && !cur.up_sync[2];
		down_edge = cur.down_sync[1] && !cur.down_sync[2];

		// Voltage-step interface target
		next_cur.step_on = STEP_PORT_ENABLE;
		if (!STEP_PORT_ENABLE || !cur.step_on) begin
			next_cur.step_target = cur.regs.step_port_base_voltage;
		end else if (up_edge && !down_edge) begin
			if (cur.step_target < cur.regs.voltage_ceiling) begin
				next_cur.step_target = cur.step_target + 7'h01;
			end
		end else if (down_edge && !up_edge) begin
			if (cur.step_target != 7'h00) begin
				next_cur.step_target = cur.step_target - 7'h01;
			end
		end

		// Active target, capped at the ceiling
		wanted = cur.step_on ? cur.step_target : SET_VOLTAGE;
		if (wanted > cur.regs.voltage_ceiling) begin
			next_cur.target = cur.regs.voltage_ceiling;
		end else begin
			next_cur.target = wanted;
		end
		next_cur.set_low_power = SET_B_SELECTED ? SET_B_LOW_POWER : SET_A_LOW_POWER;

		// Current limit and alarm threshold
		raw_limit = 13'(`LIMIT_BASE_MA + 13'(cur.regs.phase_current_limit * `LIMIT_STEP_MA));
		if (raw_limit > `LIMIT_TOP_MA) begin
			next_cur.limit_ma = `LIMIT_TOP_MA;
		end else begin
			next_cur.limit_ma = raw_limit;
		end
		margin = cur.regs.alarm_margin_sel ? `MARGIN_LARGE_MA : `MARGIN_SMALL_MA;
		next_cur.alarm_ma = next_cur.limit_ma - margin;
		next_cur.alarm = (PHASE_CURRENT > cur.alarm_ma);
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cur <= '0;
			cur.regs.phase_current_limit <= `RESET_LIMIT;
			cur.regs.ramp_down_rate <= `RESET_RAMP;
			cur.regs.ramp_up_rate <= `RESET_RAMP;
			cur.regs.op_mode <= `RESET_MODE;
			cur.regs.phase_count <= `RESET_PHASE;
			cur.regs.auto_mode_threshold <= `RESET_VOLTAGE;
			cur.regs.step_port_base_voltage <= `RESET_VOLTAGE;
			cur.regs.voltage_ceiling <= `RESET_CEILING;
			cur.limit_ma <= `LIMIT_BASE_MA;
			cur.alarm_ma <= `LIMIT_BASE_MA - `MARGIN_SMALL_MA;
		end else begin
			cur <= next_cur;
		end
	end

	ramp_gen ramp (
		.clk(CORE_CLK),
		.rst(RST),
		.enable(BUCK_ENABLE),
		.target(cur.target),
		.up_rate(cur.regs.ramp_up_rate),
		.down_rate(cur.regs.ramp_down_rate),
		.ramp_out(ramp_out)
	);

	mode_sel mode (
		.clk(CORE_CLK),
		.rst(RST),
		.regs(cur.regs),
		.set_low_power(cur.set_low_power),
		.target(cur.target),
		.dual_mode(DUAL_MODE),
		.phase_current(PHASE_CURRENT),
		.mode_out(mode_out)
	);

	assign REG_RDATA = cur.rdata;
	assign REG_RVALID = cur.rvalid;
	assign VOUT_CODE = ramp_out.vout_code;
	assign RAMP_DONE = ramp_out.done;
	assign LOW_POWER = mode_out.low_power;
	assign PHASES_ACTIVE = mode_out.phases;
	assign PHASE_SHEDDING = mode_out.shedding;
	assign CURRENT_LIMIT_MA = cur.limit_ma;
	assign ALARM_LEVEL_MA = cur.alarm_ma;
	assign OVER_CURRENT_ALARM = cur.alarm;
	assign ACTIVE_TARGET = cur.target;

endmodule

// file: tb/buck_regs_checker_assertions.sv
// Port checks of the regulator settings bank.
// Assumes binding to the bank top module, one clock, synchronous reset.
`timescale 1ns/1ps
module buck_regs_checker import buck_regs_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic DUAL_MODE,
	input wire logic LOW_POWER,
	input wire logic [3:0] PHASES_ACTIVE,
	input wire logic PHASE_SHEDDING,
	input wire logic [12:0] CURRENT_LIMIT_MA,
	input wire logic [12:0] ALARM_LEVEL_MA
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	a_read_answer: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	a_no_stray_valid: assert property (!REG_RD |=> !REG_RVALID)
		else $error("read data valid without read");
	a_rdata_stands: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
		else $error("read data changed without read");
	a_limit_grid: assert property (CURRENT_LIMIT_MA >= 1600 && CURRENT_LIMIT_MA <= 4200
		&& (CURRENT_LIMIT_MA - 1600) % 200 == 0) else $error("limit off grid");
	a_alarm_margin: assert property (ALARM_LEVEL_MA == CURRENT_LIMIT_MA - 13'h012C
		|| ALARM_LEVEL_MA == CURRENT_LIMIT_MA - 13'h0258) else $error("alarm margin wrong");
	a_phase_codes: assert property (!$past(RST) && !$past(RST, 2) |->
		PHASES_ACTIVE inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8}) else $error("bad phase count");
	a_eight_dual: assert property (PHASES_ACTIVE == 4'h8 |->
		$past(DUAL_MODE) || $past(DUAL_MODE, 2)) else $error("eight phases without dual");
	a_shed_normal: assert property (LOW_POWER && $past(LOW_POWER) && $past(LOW_POWER, 2)
		|-> !PHASE_SHEDDING) else $error("shedding in low power");
	c_read: cover property (REG_RD ##1 REG_RVALID);
	c_shed: cover property ($rose(PHASE_SHEDDING));
	c_eight: cover property (PHASES_ACTIVE == 4'h8);
endmodule
bind buck_regulator_settings_regs buck_regs_checker i_chk (.CORE_CLK(CORE_CLK), .RST(RST),
	.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .DUAL_MODE(DUAL_MODE),
	.LOW_POWER(LOW_POWER), .PHASES_ACTIVE(PHASES_ACTIVE), .PHASE_SHEDDING(PHASE_SHEDDING),
	.CURRENT_LIMIT_MA(CURRENT_LIMIT_MA), .ALARM_LEVEL_MA(ALARM_LEVEL_MA));

// file: tb/buck_regulator_settings_regs_test.sv
// Self-checking bench of the regulator settings bank.
// Assumes the bank alone, driven at its ports on a 20 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
$display("wrong value at %0t: %h vs %h", $time, g, e); end end
module buck_regulator_settings_regs_test;
	logic clk = 0, rst = 1, wr = 0, rd = 0, sp_en = 0, sel_b = 0, a_lp = 0, b_lp = 0;
	logic up = 0, dn = 0, dual = 0, en = 1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rnd;
	logic [6:0] setv = 7'h00, vout, tgt;
	logic [12:0] icur = 13'h0000, lim, alm;
	logic rvalid, done, lp, shed, oca;
	logic [3:0] ph;
	int n_errors = 0, check_count = 0, mdl[8], i, m, p;
	int mask[8] = '{8'h1F, 8'hFF, 8'h0F, 0, 8'h7F, 8'h7F, 8'h7F, 0};
	buck_regulator_settings_regs i_dut (.CORE_CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
		.BUCK_ENABLE(en), .STEP_PORT_ENABLE(sp_en), .SET_B_SELECTED(sel_b),
		.SET_A_LOW_POWER(a_lp), .SET_B_LOW_POWER(b_lp), .SET_VOLTAGE(setv), .STEP_UP(up),
		.STEP_DOWN(dn), .DUAL_MODE(dual), .PHASE_CURRENT(icur), .VOUT_CODE(vout),
		.RAMP_DONE(done), .LOW_POWER(lp), .PHASES_ACTIVE(ph), .PHASE_SHEDDING(shed),
		.CURRENT_LIMIT_MA(lim), .ALARM_LEVEL_MA(alm), .OVER_CURRENT_ALARM(oca),
		.ACTIVE_TARGET(tgt));
	initial begin
		forever #25 clk = ~clk;
	end
	task complete_run;
		if (n_errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	function int lim_of(input int c);
		lim_of = 1600 + 200 * c;
		if (lim_of > 4200) lim_of = 4200;
	endfunction
	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task wrt(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		wr = 1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#2;
		wr = 0;
		if (a != 8'hD3 && a != 8'hD7) mdl[a - 8'hD0] = d & mask[a - 8'hD0];
	endtask
	task rdc(input logic [7:0] a, input int e);
		@(posedge clk);
		#2;
		rd = 1;
		addr = a;
		@(posedge clk);
		#2;
		rd = 0;
		`CHK(rvalid, 1'b1)
		`CHK(rdata, e[7:0])
	endtask
	task stp(input logic u);
		if (u) up = 1;
		else dn = 1;
		wait_n(3);
		up = 0;
		dn = 0;
		wait_n(3);
	endtask
	initial begin
		#1000000;
		n_errors++;
		complete_run;
	end
	initial begin
		i = $urandom(32'hF5192BCA);
		repeat (12) @(posedge clk);
		#2;
		rst = 0;
		mdl = '{0, 0, 3, 0, 0, 0, 8'h7F, 0};
		for (i = 0; i < 8; i++) rdc(8'(8'hD0 + i), mdl[i]);
		for (i = 0; i < 24; i++) begin
			p = $urandom % 8;
			rnd = 8'($urandom);
			if (p == 1 && rnd[4:2] inside {3'h5, 3'h6}) rnd[4] = 1'b0;
			wrt(8'(8'hD0 + p), rnd);
			mdl[7] = mdl[5];
			rdc(8'(8'hD0 + p), mdl[p]);
			wait_n(1);
			`CHK(lim, 13'(lim_of(mdl[0] & 15)))
			`CHK(alm, 13'(lim_of(mdl[0] & 15) - (mdl[0][4] ? 600 : 300)))
		end
		wrt(8'hD6, 8'h7F);
		wrt(8'hD4, 8'h40);
		wrt(8'hD2, 8'h03);
		a_lp = 1;
		for (p = 0; p < 2; p++) for (m = 0; m < 4; m++) begin
			sel_b = p[0];
			setv = p ? 7'h50 : 7'h20;
			wrt(8'hD1, 8'(8'h1C + m));
			wait_n(4);
			`CHK(tgt, setv)
			`CHK(lp, m == 1 || (m != 2 && p == 0))
		end
		wrt(8'hD1, 8'h1E);
		for (p = 0; p < 8; p++) begin
			dual = 1'($urandom);
			wrt(8'hD2, 8'(p));
			wait_n(3);
			`CHK(ph, 4'(p < 4 ? p + 1 : (dual ? 8 : 4)))
		end
		wrt(8'hD2, 8'h0B);
		wrt(8'hD0, 8'h00);
		icur = 13'h01F4;
		wait_n(4);
		`CHK(shed, 1'b1)
		`CHK(ph, 4'h1)
		`CHK(oca, 1'b0)
		icur = 13'h0578;
		wait_n(4);
		`CHK(oca, 1'b1)
		icur = 13'h01F4;
		wrt(8'hD1, 8'h1D);
		wait_n(4);
		`CHK(shed, 1'b0)
		wrt(8'hD1, 8'h1E);
		setv = 7'h20;
		wait_n(4);
		`CHK(vout, 7'h20)
		wrt(8'hD1, 8'h02);
		setv = 7'h21;
		wait_n(20);
		`CHK(vout, 7'h20)
		wait_n(150);
		`CHK(vout, 7'h21)
		`CHK(done, 1'b1)
		wrt(8'hD6, 8'h30);
		setv = 7'h50;
		wrt(8'hD1, 8'h1E);
		wait_n(4);
		`CHK(tgt, 7'h30)
		`CHK(vout, 7'h30)
		wrt(8'hD5, 8'h2E);
		wrt(8'hD6, 8'h32);
		sp_en = 1;
		wait_n(4);
		`CHK(tgt, 7'h2E)
		for (i = 0; i < 3; i++) stp(1);
		rdc(8'hD7, 8'h31);
		for (i = 0; i < 3; i++) stp(1);
		wrt(8'hD7, 8'h00);
		rdc(8'hD7, 8'h32);
		stp(0);
		rdc(8'hD7, 8'h31);
		sp_en = 0;
		wait_n(4);
		rdc(8'hD7, 8'h2E);
		`CHK(tgt, 7'h32)
		wrt(8'hD1, 8'hA2);
		en = 0;
		wait_n(98);
		`CHK(vout, 7'h23)
		wait_n(250);
		`CHK(vout, 7'h00)
		`CHK(done, 1'b0)
		rst = 1;
		wait_n(2);
		rst = 0;
		rdc(8'hD1, 8'h00);
		`CHK(lim, 13'h0640)
		complete_run;
	end
endmodule
